// ==== core/rhs_regs.svh ====
// Register offsets, fields, hash lengths and counts for receive hash steering.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef RHS_REGS_SVH
`define RHS_REGS_SVH
`define RHS_CTRL_OFF 12'h000
`define RHS_BASE_OFF 12'h004
`define RHS_STAT_OFF 12'h008
`define RHS_HASH_OFF 12'h00C
`define RHS_ACK_OFF 12'h010
`define RHS_KEY_OFF 12'h040
`define RHS_KEY_WORDS 10
`define RHS_ITAB_PAGE 4'h1
`define RHS_VEC_PAGE 7'h10
`define RHS_PEND_LO_OFF 12'h280
`define RHS_PEND_HI_OFF 12'h284
`define RHS_CTRL_EN 0
`define RHS_CTRL_FUNC 1
`define RHS_CTRL_TYPE 2
`define RHS_CTRL_BITS 6
`define RHS_CTRL_METH 9
`define RHS_TYPE_TCP4 0
`define RHS_TYPE_IP4 1
`define RHS_TYPE_TCP6 2
`define RHS_TYPE_IP6 3
`define RHS_METH_LEGACY 2'h0
`define RHS_METH_MSI 2'h1
`define RHS_METH_TABLE 2'h2
`define RHS_KEY_BITS 320
`define RHS_IN_BITS 288
`define RHS_LEN_IP4 9'h040
`define RHS_LEN_TCP4 9'h060
`define RHS_LEN_IP6 9'h100
`define RHS_LEN_TCP6 9'h120
`define RHS_ITAB_ENTRIES 64
`define RHS_VECTORS 4
`define RHS_ITAB_MAX_BITS 3'h6
`define RHS_RD_ZERO 32'h0000_0000
`endif

// ==== core/rhs_pkg.sv ====
// Types shared by the receive hash steering block.
// Assumes rhs_regs.svh for sizes.
`include "rhs_regs.svh"
package rhs_pkg;
  typedef enum logic [1:0] {IDLE, HASH, LOOKUP} rhs_state_t;
  typedef struct packed {
    logic valid;
    logic isIpv4;
    logic isIpv6;
    logic isTcp;
    logic [127:0] srcAddr;
    logic [127:0] dstAddr;
    logic [15:0] srcPort;
    logic [15:0] dstPort;
  } rhs_pkt_t;
  typedef struct packed {
    logic steered;
    logic [7:0] queue;
    logic [31:0] hash;
  } rhs_res_t;
  typedef struct packed {
    logic [1:0] entry;
    logic [31:0] data;
  } rhs_msg_t;
  typedef struct packed {
    logic steerEn;
    logic hashFunc;
    logic [3:0] typeEn;
    logic [2:0] hashBits;
    logic [1:0] method;
    logic [7:0] base;
    logic [`RHS_KEY_BITS-1:0] key;
    logic [`RHS_ITAB_ENTRIES-1:0][7:0] itab;
    logic [`RHS_VECTORS-1:0][31:0] vecData;
    logic [`RHS_VECTORS-1:0] vecMask;
    logic [`RHS_VECTORS-1:0] pend;
    rhs_state_t state;
    logic [8:0] cnt;
    logic [8:0] len;
    logic [`RHS_IN_BITS-1:0] shin;
    logic [31:0] hash;
    logic primary;
    logic pktRdy;
    logic resValid;
    rhs_res_t res;
    logic msgValid;
    rhs_msg_t msg;
    logic legacyIrq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rhs_st_t;
endpackage

// ==== core/rhs_steer.sv ====
// Receive hash steering with keyed hash, indirection table and vector table.
// Assumes an APB master on clk and packet descriptors from logic on clk.
`timescale 1ns/1ps
`include "rhs_regs.svh"

// How it works
// - Message data word sent exactly as stored
// - Vector control upper bits read zero
// - Masked entry never emits a message in table method; single method ignores the mask
// - Each entry masked on its own
// - All entries masked after reset
// - Pending array marks waiting messages
// - Pending bits reset to zero
// - Steering parameters stored before steering starts
// - Keyed Toeplitz hash is the default
// - TCP4 hashes addresses and both ports
// - IPv4 hashes both addresses only
// - TCP6 hashes addresses and both ports
// - IPv6 hashes addresses, no extension headers
// - Hash low bits index the table
// - Lowest CPU offset added to entry
// - Every matching packet hashed and steered to queue
// - Unmatched packet goes to primary queue
// - Stored key feeds the hash
// - Table rewrites apply to later packets
// - Legacy, single or table message notification
module rhs_steer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rhs_pkg::rhs_pkt_t pkt,
  output logic pktReady,
  output logic resValid,
  output rhs_pkg::rhs_res_t res,
  output logic msgValid,
  input wire logic msgReady,
  output rhs_pkg::rhs_msg_t msg,
  output logic legacyIrq
);
  rhs_pkg::rhs_st_t st_q;
  rhs_pkg::rhs_st_t st_d;

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state
  logic accept;
  logic mTcp4;
  logic mIp4;
  logic mTcp6;
  logic mIp6;
  logic [5:0] idxMask;
  logic [5:0] idx;
  logic [31:0] rdVal;
  logic rdErr;
  logic [3:0] evtSet;
  logic [3:0] msgClr;
  logic [1:0] pick;
  logic pickOk;

  assign accept = (st_q.state == rhs_pkg::IDLE) && pkt.valid;
  assign mTcp4 = st_q.steerEn && pkt.isIpv4 && pkt.isTcp && st_q.typeEn[`RHS_TYPE_TCP4];
  assign mIp4 = st_q.steerEn && pkt.isIpv4 && st_q.typeEn[`RHS_TYPE_IP4];
  assign mTcp6 = st_q.steerEn && pkt.isIpv6 && pkt.isTcp && st_q.typeEn[`RHS_TYPE_TCP6];
  assign mIp6 = st_q.steerEn && pkt.isIpv6 && st_q.typeEn[`RHS_TYPE_IP6];
  assign idxMask = 6'((7'h01 << st_q.hashBits) - 7'h01);
  assign idx = st_q.hash[5:0] & idxMask;

  // Register read decode
  always_comb begin
    rdVal = `RHS_RD_ZERO;
    rdErr = 1'b0;
    if (paddr[11:8] == `RHS_ITAB_PAGE) begin
      rdVal = {24'h00_0000, st_q.itab[paddr[7:2]]};
    end else if (paddr[11:5] == `RHS_VEC_PAGE) begin
      if (paddr[2]) begin
        rdVal = {31'h0000_0000, st_q.vecMask[paddr[4:3]]};
      end else begin
        rdVal = st_q.vecData[paddr[4:3]];
      end
    end else if (paddr >= `RHS_KEY_OFF && paddr < `RHS_KEY_OFF + 12'h028) begin
      // Word at the lowest key offset holds the most significant key bits
      rdVal = st_q.key[(`RHS_KEY_WORDS - 1 - 32'(paddr[5:2])) * 32 +: 32];
    end else begin
      case (paddr)
        `RHS_CTRL_OFF: rdVal = {21'h00_0000, st_q.method, st_q.hashBits, st_q.typeEn,
                                st_q.hashFunc, st_q.steerEn};
        `RHS_BASE_OFF: rdVal = {24'h00_0000, st_q.base};
        `RHS_STAT_OFF: rdVal = {23'h00_0000, st_q.state != rhs_pkg::IDLE, st_q.res.queue};
        `RHS_HASH_OFF: rdVal = st_q.res.hash;
        `RHS_ACK_OFF: rdVal = `RHS_RD_ZERO;
        `RHS_PEND_LO_OFF: rdVal = {28'h000_0000, st_q.pend};
        `RHS_PEND_HI_OFF: rdVal = `RHS_RD_ZERO;
        default: rdErr = 1'b1;
      endcase
    end
  end

  // Lowest pending entry that may send
  always_comb begin
    pick = 2'h0;
    pickOk = 1'b0;
    for (int i = `RHS_VECTORS - 1; i >= 0; i--) begin
      if (st_q.pend[i] && (!st_q.vecMask[i] || st_q.method == `RHS_METH_MSI)) begin
        pick = 2'(i);
        pickOk = 1'b1;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    evtSet = 4'h0;
    msgClr = 4'h0;
    st_d.resValid = 1'b0;
    // APB: answer one cycle into access, commit on the edge pready is seen
    if (psel && penable && !st_q.pready) begin
      st_d.pready = 1'b1;
      st_d.prdata = rdErr ? `RHS_RD_ZERO : rdVal;
      st_d.pslverr = rdErr;
    end else begin
      st_d.pready = 1'b0;
      st_d.pslverr = 1'b0;
    end
    if (psel && penable && st_q.pready && pwrite && !st_q.pslverr) begin
      if (paddr[11:8] == `RHS_ITAB_PAGE) begin
        st_d.itab[paddr[7:2]] = pwdata[7:0];
      end else if (paddr[11:5] == `RHS_VEC_PAGE) begin
        if (paddr[2]) begin
          st_d.vecMask[paddr[4:3]] = pwdata[0];
        end else begin
          st_d.vecData[paddr[4:3]] = pwdata;
        end
      end else if (paddr >= `RHS_KEY_OFF && paddr < `RHS_KEY_OFF + 12'h028) begin
        st_d.key[(`RHS_KEY_WORDS - 1 - 32'(paddr[5:2])) * 32 +: 32] = pwdata;
      end else begin
        case (paddr)
          `RHS_CTRL_OFF: begin
            st_d.steerEn = pwdata[`RHS_CTRL_EN];
            st_d.hashFunc = pwdata[`RHS_CTRL_FUNC];
            st_d.typeEn = pwdata[`RHS_CTRL_TYPE +: 4];
            st_d.hashBits = (pwdata[`RHS_CTRL_BITS +: 3] > `RHS_ITAB_MAX_BITS) ?
                            `RHS_ITAB_MAX_BITS : pwdata[`RHS_CTRL_BITS +: 3];
            st_d.method = pwdata[`RHS_CTRL_METH +: 2];
          end
          `RHS_BASE_OFF: st_d.base = pwdata[7:0];
          `RHS_ACK_OFF: msgClr = pwdata[3:0];
          default: st_d.base = st_q.base;
        endcase
      end
    end

    // Packet path
    case (st_q.state)
      rhs_pkg::IDLE: begin
        if (accept) begin
          st_d.hash = 32'h0000_0000;
          st_d.cnt = 9'h000;
          st_d.primary = 1'b0;
          st_d.state = rhs_pkg::HASH;
          if (mTcp4) begin
            st_d.len = `RHS_LEN_TCP4;
            st_d.shin = {pkt.srcAddr[31:0], pkt.dstAddr[31:0], pkt.srcPort, pkt.dstPort,
                         192'h0};
          end else if (mIp4) begin
            st_d.len = `RHS_LEN_IP4;
            st_d.shin = {pkt.srcAddr[31:0], pkt.dstAddr[31:0], 224'h0};
          end else if (mTcp6) begin
            st_d.len = `RHS_LEN_TCP6;
            st_d.shin = {pkt.srcAddr, pkt.dstAddr, pkt.srcPort, pkt.dstPort};
          end else if (mIp6) begin
            st_d.len = `RHS_LEN_IP6;
            st_d.shin = {pkt.srcAddr, pkt.dstAddr, 32'h0000_0000};
          end else begin
            st_d.primary = 1'b1;
            st_d.state = rhs_pkg::LOOKUP;
          end
        end
      end
      rhs_pkg::HASH: begin
        // Toeplitz fold; the function select has no other option so it is ignored
        if (st_q.shin[`RHS_IN_BITS-1]) begin
          st_d.hash = st_q.hash ^ st_q.key[(`RHS_KEY_BITS - 1) - 32'(st_q.cnt) -: 32];
        end
        st_d.shin = {st_q.shin[`RHS_IN_BITS-2:0], 1'b0};
        st_d.cnt = st_q.cnt + 9'h001;
        if (st_q.cnt == st_q.len - 9'h001) begin
          st_d.state = rhs_pkg::LOOKUP;
        end
      end
      rhs_pkg::LOOKUP: begin
        st_d.resValid = 1'b1;
        st_d.res.steered = !st_q.primary;
        st_d.res.hash = st_q.primary ? 32'h0000_0000 : st_q.hash;
        st_d.res.queue = st_q.primary ? 8'h00 : st_q.itab[idx] + st_q.base;
        evtSet[st_d.res.queue[1:0] & {2{st_q.method == `RHS_METH_TABLE}}] = 1'b1;
        st_d.state = rhs_pkg::IDLE;
      end
      default: st_d.state = rhs_pkg::IDLE;
    endcase
    st_d.pktRdy = (st_d.state == rhs_pkg::IDLE);

    // Notification, a new event wins over a clear in the same cycle
    if (st_q.msgValid && msgReady) begin
      st_d.msgValid = 1'b0;
      msgClr[st_q.msg.entry] = 1'b1;
    end else if (!st_q.msgValid && pickOk && st_q.method != `RHS_METH_LEGACY) begin
      st_d.msgValid = 1'b1;
      st_d.msg.entry = pick;
      st_d.msg.data = st_q.vecData[pick];
    end
    st_d.pend = (st_q.pend & ~msgClr) | evtSet;
    st_d.legacyIrq = (st_q.method == `RHS_METH_LEGACY) && (|st_d.pend);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.vecMask <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign pktReady = st_q.pktRdy;
  assign resValid = st_q.resValid;
  assign res = st_q.res;
  assign msgValid = st_q.msgValid;
  assign msg = st_q.msg;
  assign legacyIrq = st_q.legacyIrq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence tcp4Take;
    accept && mTcp4;
  endsequence
  sequence plainTake;
    accept && !(mTcp4 || mIp4 || mTcp6 || mIp6);
  endsequence

  mask_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(msgValid) && st_q.method == `RHS_METH_TABLE |-> !$past(st_q.vecMask[pick]))
    else $error("Masked entry sent a message");
  data_kept_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(msgValid) |-> msg.data == $past(st_q.vecData[pick]))
    else $error("Message data altered");
  msg_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    msgValid && !msgReady |=> msgValid && $stable(msg))
    else $error("Message changed before it was taken");
  legacy_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(msgValid) |-> $past(st_q.method) != `RHS_METH_LEGACY)
    else $error("Message sent in legacy method");
  msg_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
    msgValid && msgReady |=> !msgValid)
    else $error("Message still valid after it was taken");
  apb_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready |=> !pready)
    else $error("Ready held longer than one cycle");
  err_with_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    pslverr |-> pready)
    else $error("Error flagged without ready");
  res_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    resValid |=> !resValid)
    else $error("Result valid held longer than one cycle");
  idle_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    pktReady |-> st_q.state == rhs_pkg::IDLE)
    else $error("Ready for a packet while busy");
  primary_hash_a: assert property (@(posedge clk) disable iff (!rst_n)
    resValid && !res.steered |-> res.hash == 32'h0000_0000 && res.queue == 8'h00)
    else $error("Unsteered result not on primary queue");
  reset_masked_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> st_q.vecMask == 4'hF && st_q.pend == 4'h0)
    else $error("Bad vector state after reset");
  ctrl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready && !pwrite && paddr[11:5] == `RHS_VEC_PAGE && paddr[2] |-> prdata[31:1] == 31'h0)
    else $error("Reserved control bits not zero");
  pend_hi_a: assert property (@(posedge clk) disable iff (!rst_n)
    pready && !pwrite && paddr == `RHS_PEND_HI_OFF |-> prdata == 32'h0000_0000)
    else $error("Reserved pending bits set");
  primary_q_a: assert property (@(posedge clk) disable iff (!rst_n)
    plainTake |-> ##2 resValid && res.queue == 8'h00 && !res.steered)
    else $error("Unmatched packet not sent to primary queue");
  tcp4_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    tcp4Take |-> ##1 !pktReady[*8] ##89 !resValid ##1 resValid && res.steered)
    else $error("TCP4 hash length wrong");
  cpu_sum_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_q.state == rhs_pkg::LOOKUP && !st_q.primary
    |=> res.queue == $past(st_q.itab[idx]) + $past(st_q.base))
    else $error("Queue is not table entry plus offset");
  pend_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    resValid && st_q.method == `RHS_METH_TABLE && st_q.vecMask[res.queue[1:0]]
    |-> st_q.pend[res.queue[1:0]])
    else $error("Pending bit not set for masked entry");
endmodule

// ==== testbench/rhs_msg_sink.sv ====
// Host-side sink for vector table messages.
// Assumes msgValid and msg hold until msgReady is seen high.
`timescale 1ns/1ps
module rhs_msg_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic msgValid,
  output logic msgReady,
  input wire rhs_pkg::rhs_msg_t msg,
  output int count,
  output rhs_pkg::rhs_msg_t last
);
  // Slow host holds ready low
  assign msgReady = !stall;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= 0;
      last <= '0;
    end else if (msgValid && msgReady) begin
      count <= count + 1;
      last <= msg;
    end
  end
endmodule

// ==== testbench/rx_hash_steering_msix_test.sv ====
// Self-checking bench for the hash steering block.
// Assumes APB with one wait state and the sink model beside the design.
`timescale 1ns/1ps
`include "rhs_regs.svh"
module rx_hash_steering_msix_test;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, h;
  logic pready, pslverr, err, pktReady, resValid, msgValid, msgReady, legacyIrq;
  rhs_pkg::rhs_pkt_t pkt = '0;
  rhs_pkg::rhs_res_t res, r;
  rhs_pkg::rhs_msg_t msg, last;
  int count, errorCnt = 0, totalChecks = 0;
  logic [319:0] key;
  logic [7:0] itab [64];
  logic [7:0] q;
  rhs_steer i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt(pkt), .pktReady(pktReady), .resValid(resValid), .res(res), .msgValid(msgValid),
    .msgReady(msgReady), .msg(msg), .legacyIrq(legacyIrq));
  rhs_msg_sink i_sink (.clk(clk), .rst_n(rst_n), .stall(stall), .msgValid(msgValid),
    .msgReady(msgReady), .msg(msg), .count(count), .last(last));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks=%0d errors=%0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stuck();
    errorCnt++;
    results();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) stuck();
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, '0);
    chk(rd, exp);
  endtask
  task automatic send(input logic tcp, input logic v6, input logic [31:0] s);
    int n;
    rhs_pkg::rhs_pkt_t p;
    n = 0;
    p = '0;
    p.valid = 1;
    p.isIpv4 = !v6;
    p.isIpv6 = v6;
    p.isTcp = tcp;
    p.srcAddr = {96'h0, s};
    p.dstAddr = {96'h0, 32'hc0a8_0001};
    p.srcPort = 16'h1f90;
    p.dstPort = 16'h0050;
    pkt <= p;
    do begin
      @(posedge clk);
      n++;
      if (n > 400) stuck();
    end while (pktReady !== 1'b1);
    pkt <= '0;
    do begin
      @(posedge clk);
      n++;
      if (n > 400) stuck();
    end while (resValid !== 1'b1);
    r = res;
  endtask
  function automatic logic [31:0] toep(input logic [287:0] v, input int len);
    logic [31:0] x;
    x = '0;
    for (int i = 0; i < len; i++) if (v[287-i]) x ^= key[319-i -: 32];
    return x;
  endfunction
  task automatic waitmsg(input int exp);
    for (int i = 0; i < 50 && count != exp; i++) @(posedge clk);
    chk(count, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    for (int n = 0; n < 4; n++) rchk(12'h204 + 12'(8 * n), 32'h0000_0001);
    rchk(12'h280, 32'h0000_0000);
    rchk(12'h284, 32'h0000_0000);
    for (int n = 0; n < 4; n++) apb(1, 12'h200 + 12'(8 * n), 32'hc0de_0000 | n);
    for (int n = 0; n < 4; n++) rchk(12'h200 + 12'(8 * n), 32'hc0de_0000 | n);
    apb(0, 12'h300, '0);
    chk({err, rd}, 33'h1_0000_0000);
    $display("register test done");
    for (int i = 0; i < 10; i++) begin
      key[319 - 32 * i -: 32] = 32'h6d5a_56da + 32'(i * 32'h0101_0301);
      apb(1, 12'h040 + 12'(4 * i), key[319 - 32 * i -: 32]);
    end
    for (int j = 0; j < 64; j++) begin
      itab[j] = 8'(j * 3);
      apb(1, 12'h100 + 12'(4 * j), {24'h0, itab[j]});
    end
    apb(1, 12'h004, 32'h0000_0010);
    apb(1, 12'h000, 32'h0000_058d);
    send(0, 0, 32'h0a00_0002);
    h = toep({32'h0a00_0002, 32'hc0a8_0001, 224'h0}, 64);
    q = itab[h[5:0]] + 8'h10;
    chk(r, {1'b1, q, h});
    waitmsg(0);
    rchk(12'h280, 32'(1 << q[1:0]));
    stall <= 1;
    apb(1, 12'h204 + 12'(8 * q[1:0]), 32'h0000_0000);
    repeat (5) @(posedge clk);
    chk(count, 0);
    stall <= 0;
    waitmsg(1);
    chk(last, {q[1:0], 32'hc0de_0000 | q[1:0]});
    rchk(12'h280, 32'h0000_0000);
    $display("ipv4 test done");
    send(1, 0, 32'h0a00_0003);
    h = toep({32'h0a00_0003, 32'hc0a8_0001, 16'h1f90, 16'h0050, 192'h0}, 96);
    chk(r, {1'b1, itab[h[5:0]] + 8'h10, h});
    send(1, 1, 32'h0a00_0003);
    chk(r[40:32], 9'h0);
    $display("tcp test done");
    send(0, 0, 32'h0a00_0002);
    h = toep({32'h0a00_0002, 32'hc0a8_0001, 224'h0}, 64);
    apb(1, 12'h100 + 12'(4 * h[5:0]), 32'h0000_0077);
    send(0, 0, 32'h0a00_0002);
    chk(r, {1'b1, 8'h87, h});
    $display("table rewrite test done");
    apb(1, 12'h000, 32'h0000_018d);
    apb(1, 12'h010, 32'h0000_000f);
    chk(legacyIrq, 1'b0);
    send(0, 0, 32'h0a00_0002);
    @(posedge clk);
    chk(legacyIrq, 1'b1);
    apb(1, 12'h010, 32'h0000_000f);
    chk(legacyIrq, 1'b0);
    $display("legacy test done");
    results();
  end
endmodule
